// ### hw/ccf_top.sv
// current channel fault select, channel gain trim, integrator and zero-cross
// assumes an AHB-Lite master on hclk and ADC samples qualified by samp_valid
`timescale 1ns/1ps
`default_nettype none
`include "ccf_regs.svh"

module ccf_top import ccf_pkg::*; #(
  parameter int unsigned SWAP_CYCLES = `CCF_SWAP_CYC
) (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // adc sample streams
  input  wire logic                samp_valid,
  input  wire logic signed [23:0]  first_current_input,
  input  wire logic signed [23:0]  second_current_input,
  input  wire logic signed [23:0]  voltage_sample,
  // measurement output
  output logic signed [24:0]       i_meas,
  output logic                     i_meas_valid,
  // zero cross and port pins
  output logic                     zero_cross_signal,
  output logic                     p0_5_zx,
  output logic                     p1_2_zx,
  // interrupt
  output logic                     irq
);

  // ---------------- bus front end ----------------
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  idx_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic        hresp_q;

  wire         addr_ok = hsel & htrans[1] & hready;
  wire         wr_phase = wr_pend_q;
  wire [7:0]   idx_now = haddr[9:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      idx_q       <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q   <= addr_ok & hwrite;
      rd_pend_q   <= addr_ok & ~hwrite;
      hreadyout_q <= ~(addr_ok & ~hwrite);
      hresp_q     <= 1'b0;
      if (addr_ok) begin
        idx_q <= idx_now;
      end
    end
  end

  wire wr_mode_one_control  = wr_phase & (idx_q == `CCF_IDX_MODE_ONE_CONTROL);
  wire wr_acc    = wr_phase & (idx_q == `CCF_IDX_ACCUMULATION_MODE_CONTROL);
  wire wr_gain   = wr_phase & (idx_q == `CCF_IDX_GAIN);
  wire wr_cal    = wr_phase & (idx_q == `CCF_IDX_CALIBRATION_MODE_CONTROL);
  wire wr_zxr    = wr_phase & (idx_q == `CCF_IDX_ZXROUTE);
  wire wr_irqen  = wr_phase & (idx_q == `CCF_IDX_IRQEN);
  wire wr_status = wr_phase & (idx_q == `CCF_IDX_STATUS);

  // ---------------- software registers ----------------
  logic [7:0]  mode_one_control_q;
  logic        fsign_mode_q;
  logic [11:0] gain_q;
  logic [7:0]  calibration_mode_control_q;
  logic [1:0]  zxroute_q;
  logic [7:0]  irqen_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_one_control_q      <= `CCF_RST_REG8;
      fsign_mode_q <= 1'b0;
      gain_q       <= `CCF_RST_GAIN;
      calibration_mode_control_q    <= `CCF_RST_REG8;
      zxroute_q    <= 2'b00;
      irqen_q      <= `CCF_RST_REG8;
    end else begin
      if (wr_mode_one_control) mode_one_control_q <= hwdata[7:0];
      if (wr_acc) fsign_mode_q <= hwdata[`CCF_ACC_FSIGN];
      if (wr_gain) gain_q <= hwdata[11:0];
      if (wr_cal) calibration_mode_control_q <= hwdata[7:0];
      if (wr_zxr) zxroute_q <= hwdata[1:0];
      if (wr_irqen) irqen_q <= hwdata[7:0];
    end
  end

  wire       integ_on = mode_one_control_q[`CCF_MODE_ONE_CONTROL_INTEG];
  wire       lp_bypass = mode_one_control_q[`CCF_MODE_ONE_CONTROL_LPBYP];
  wire [1:0] forced_channel_select = calibration_mode_control_q[`CCF_CAL_SEL_HI:`CCF_CAL_SEL_LO];

  // ---------------- second input gain trim ----------------
  wire signed [24:0] ia_ext = {first_current_input[23], first_current_input};
  wire signed [24:0] ib_ext = {second_current_input[23], second_current_input};
  wire signed [36:0] ib_prod = ib_ext * $signed(gain_q);
  wire signed [24:0] ib_trim = ib_ext + ib_prod[36:12];

  // ---------------- rectified averages ----------------
  wire [24:0] ia_abs = ia_ext[24] ? 25'(-ia_ext) : 25'(ia_ext);
  wire [24:0] ib_abs = ib_trim[24] ? 25'(-ib_trim) : 25'(ib_trim);

  logic [32:0] avg_a_q;
  logic [32:0] avg_b_q;
  wire  [24:0] mean_a = avg_a_q[32:`CCF_AVG_SH];
  wire  [24:0] mean_b = avg_b_q[32:`CCF_AVG_SH];
  wire  [32:0] avg_a_d = avg_a_q + {8'h00, ia_abs} - {8'h00, mean_a};
  wire  [32:0] avg_b_d = avg_b_q + {8'h00, ib_abs} - {8'h00, mean_b};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg_a_q <= 33'h0_0000_0000;
      avg_b_q <= 33'h0_0000_0000;
    end else if (samp_valid) begin
      avg_a_q <= avg_a_d;
      avg_b_q <= avg_b_d;
    end
  end

  // margin is one sixteenth of the second input, i.e. 6.25%
  wire [25:0] ma      = {1'b0, mean_a};
  wire [25:0] mb      = {1'b0, mean_b};
  wire [25:0] margin  = {5'h00, mean_b[24:4]};
  wire        b_over  = mb > (ma + margin);
  wire        a_over  = ma > (mb + margin);
  wire        a_near  = ((ma + margin) >= mb) && (ma <= (mb + margin));

  // ---------------- automatic selector ----------------
  ccf_sel_e    sel_q;
  ccf_sel_e    sel_d;
  logic [26:0] dwell_q;
  logic [26:0] dwell_d;
  logic        swap_ev;

  wire        want_swap = (sel_q == CCF_ON_A) ? b_over : a_over;
  wire [26:0] dwell_end = 27'(SWAP_CYCLES - 1);

  always_comb begin
    sel_d   = sel_q;
    dwell_d = 27'h000_0000;
    swap_ev = 1'b0;
    if (want_swap) begin
      dwell_d = dwell_q + 27'h000_0001;
      if (dwell_q >= dwell_end) begin
        dwell_d = 27'h000_0000;
        swap_ev = 1'b1;
        unique case (sel_q)
          CCF_ON_A: sel_d = CCF_ON_B;
          CCF_ON_B: sel_d = CCF_ON_A;
          default:  sel_d = CCF_ON_A;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q   <= CCF_ON_A;
      dwell_q <= 27'h000_0000;
    end else begin
      sel_q   <= sel_d;
      dwell_q <= dwell_d;
    end
  end

  // forced field wins when it holds 01 or 10
  wire forced_a = (forced_channel_select == 2'b01);
  wire forced_b = (forced_channel_select == 2'b10);
  wire use_b_d  = forced_b | (~forced_a & (sel_q == CCF_ON_B));

  logic active_channel_indicator;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) active_channel_indicator <= 1'b0;
    else          active_channel_indicator <= use_b_d;
  end

  // ---------------- integrator and measurement ----------------
  wire signed [24:0] i_sel = active_channel_indicator ? ib_trim : ia_ext;
  logic signed [39:0] integ_q;
  wire  signed [39:0] integ_d = integ_q + 40'(i_sel) - (integ_q >>> `CCF_INT_LEAK_SH);
  wire  signed [24:0] integ_out = integ_q[30:6];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)         integ_q <= 40'h00_0000_0000;
    else if (!integ_on)   integ_q <= 40'h00_0000_0000;
    else if (samp_valid)  integ_q <= integ_d;
  end

  logic signed [24:0] i_meas_q;
  logic               i_meas_valid_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_meas_q       <= 25'h000_0000;
      i_meas_valid_q <= 1'b0;
    end else begin
      i_meas_valid_q <= samp_valid;
      if (samp_valid) i_meas_q <= integ_on ? integ_out : i_sel;
    end
  end

  // ---------------- zero cross ----------------
  // pole at fs/(2*pi*64), 63.7 Hz for 25.6 kSPS samples
  logic signed [29:0] lpf_q;
  wire  signed [29:0] lpf_d = lpf_q + 30'(voltage_sample) - (lpf_q >>> `CCF_LPF_SH);
  wire  signed [23:0] lpf_out = lpf_q[29:6];
  wire                zx_src = lp_bypass ? ~voltage_sample[23] : ~lpf_out[23];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)        lpf_q <= 30'h0000_0000;
    else if (samp_valid) lpf_q <= lpf_d;
  end

  logic zx_q;
  logic p05_q;
  logic p12_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zx_q  <= 1'b0;
      p05_q <= 1'b0;
      p12_q <= 1'b0;
    end else begin
      if (samp_valid) zx_q <= zx_src;
      p05_q <= zxroute_q[`CCF_ZXR_P05] & zx_q;
      p12_q <= zxroute_q[`CCF_ZXR_P12] & zx_q;
    end
  end

  logic zx_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) zx_prev_q <= 1'b0;
    else          zx_prev_q <= zx_q;
  end
  wire zx_ev = zx_q ^ zx_prev_q;

  // ---------------- status and interrupt ----------------
  wire fault_ev = fsign_mode_q ? (a_near & samp_valid) : swap_ev;

  logic [7:0] status_q;
  wire  [7:0] ev_vec = {2'b00, fault_ev, zx_ev, 4'h0};
  wire  [7:0] clr_vec = wr_status ? hwdata[7:0] : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) status_q <= `CCF_RST_REG8;
    else          status_q <= (status_q & ~clr_vec) | ev_vec;
  end

  logic irq_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_q <= 1'b0;
    else          irq_q <= |(status_q & irqen_q);
  end

  // ---------------- read mux ----------------
  wire [7:0] acc_rd = {active_channel_indicator, fsign_mode_q, 6'h00};
  wire [31:0] rd_mux =
    (idx_q == `CCF_IDX_MODE_ONE_CONTROL)   ? {24'h00_0000, mode_one_control_q}           :
    (idx_q == `CCF_IDX_ACCUMULATION_MODE_CONTROL) ? {24'h00_0000, acc_rd}            :
    (idx_q == `CCF_IDX_GAIN)    ? {20'h0_0000, gain_q}             :
    (idx_q == `CCF_IDX_CALIBRATION_MODE_CONTROL) ? {24'h00_0000, calibration_mode_control_q}         :
    (idx_q == `CCF_IDX_ZXROUTE) ? {30'h0000_0000, zxroute_q}       :
    (idx_q == `CCF_IDX_IRQEN)   ? {24'h00_0000, irqen_q}           :
    (idx_q == `CCF_IDX_STATUS)  ? {24'h00_0000, status_q}          :
                                  32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)       hrdata_q <= 32'h0000_0000;
    else if (rd_pend_q) hrdata_q <= rd_mux;
  end

  assign hreadyout         = hreadyout_q;
  assign hrdata            = hrdata_q;
  assign hresp             = hresp_q;
  assign i_meas            = i_meas_q;
  assign i_meas_valid      = i_meas_valid_q;
  assign zero_cross_signal = zx_q;
  assign p0_5_zx           = p05_q;
  assign p1_2_zx           = p12_q;
  assign irq               = irq_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FAULT_ON_SWAP: assert property (
    (swap_ev && !fsign_mode_q) |=> status_q[`CCF_ST_FAULT])
    else $error("fault flag not set after channel swap");

  AST_SWAP_TO_B: assert property (
    (sel_q == CCF_ON_A && swap_ev) |=> (sel_q == CCF_ON_B))
    else $error("selector did not move to second input");

  AST_SWAP_DWELL: assert property (
    $changed(sel_q) |-> ($past(dwell_q) == dwell_end))
    else $error("swap happened before persistence time");

  AST_RETURN_NEEDS_A: assert property (
    ($past(sel_q) == CCF_ON_B && sel_q == CCF_ON_A) |-> $past(a_over))
    else $error("return to first input without margin");

  AST_NEAR_FLAG: assert property (
    (fsign_mode_q && a_near && samp_valid) |=> status_q[`CCF_ST_FAULT])
    else $error("near condition did not raise fault flag");

  AST_FORCED_SEL: assert property (
    (forced_a |=> !active_channel_indicator) and (forced_b |=> active_channel_indicator))
    else $error("forced channel not honoured");

  AST_INDICATOR: assert property (
    (forced_channel_select inside {2'b00, 2'b11}) |=>
      (active_channel_indicator == ($past(sel_q) == CCF_ON_B)))
    else $error("indicator does not follow automatic selector");

  AST_INTEG_OFF: assert property (
    !integ_on |=> (integ_q == 40'h00_0000_0000))
    else $error("integrator state kept while disabled");

  AST_IRQ_LEVEL: assert property (
    (status_q[`CCF_ST_FAULT] && irqen_q[`CCF_ST_FAULT]) |=> irq_q)
    else $error("interrupt not pending for enabled fault");

  AST_FLAG_STICKY: assert property (
    (status_q[`CCF_ST_FAULT] && !(wr_status && hwdata[`CCF_ST_FAULT]))
      |=> status_q[`CCF_ST_FAULT])
    else $error("fault flag dropped without a clear");

  AST_ZX_PIN: assert property (
    zxroute_q[`CCF_ZXR_P05] && $stable(zxroute_q) |=> (p05_q == $past(zx_q)))
    else $error("zero cross not routed to pin");

  AST_READ_WAIT: assert property (
    (addr_ok && !hwrite) |=> !hreadyout_q ##1 hreadyout_q)
    else $error("read answer timing wrong");

  AST_SEL_HOLD: assert property (
    !want_swap |=> $stable(sel_q))
    else $error("selector moved without a held condition");

  AST_FLAG_CLEAR: assert property (
    (wr_status && hwdata[`CCF_ST_FAULT] && !fault_ev) |=> !status_q[`CCF_ST_FAULT])
    else $error("fault flag not cleared by software");

  AST_IRQ_MASKED: assert property (
    ((status_q & irqen_q) == 8'h00) |=> !irq_q)
    else $error("interrupt pending with nothing enabled");

  AST_ZX_BYPASS: assert property (
    (samp_valid && lp_bypass) |=> (zx_q == !$past(voltage_sample[23])))
    else $error("bypassed zero cross does not follow the sample sign");

  COV_SWAP_B: cover property (sel_q == CCF_ON_A ##1 sel_q == CCF_ON_B);
  COV_SWAP_BACK: cover property (sel_q == CCF_ON_B ##1 sel_q == CCF_ON_A);
  COV_IRQ: cover property (!irq_q ##1 irq_q);
  COV_FORCED_B: cover property (forced_b ##1 active_channel_indicator);
  COV_NEAR_FLAG: cover property (fsign_mode_q && a_near && samp_valid);

endmodule // ccf_top

`default_nettype wire

// ### hw/ccf_regs.svh
// register map, field positions, reset values and timing counts
// assumes a 40 MHz hclk and one ADC sample strobe per conversion
`ifndef CCF_REGS_SVH
`define CCF_REGS_SVH

// register indices; byte address is four times the index
`define CCF_IDX_MODE_ONE_CONTROL      8'h0B
`define CCF_IDX_ACCUMULATION_MODE_CONTROL    8'h0F
`define CCF_IDX_GAIN       8'h1C
`define CCF_IDX_CALIBRATION_MODE_CONTROL    8'h3D
`define CCF_IDX_ZXROUTE    8'h40
`define CCF_IDX_IRQEN      8'hD9
`define CCF_IDX_STATUS     8'hDC

// field positions
`define CCF_MODE_ONE_CONTROL_INTEG    5
`define CCF_MODE_ONE_CONTROL_LPBYP    6
`define CCF_ACC_FSIGN      6
`define CCF_ACC_ICHAN      7
`define CCF_CAL_SEL_LO     4
`define CCF_CAL_SEL_HI     5
`define CCF_ST_ZX          4
`define CCF_ST_FAULT       5
`define CCF_ZXR_P05        0
`define CCF_ZXR_P12        1

// reset values
`define CCF_RST_REG8       8'h00
`define CCF_RST_GAIN       12'h000

// filter shifts: averaging, integrator leak and scale, zero-cross pole
`define CCF_AVG_SH         8
`define CCF_INT_LEAK_SH    10
`define CCF_INT_OUT_SH     6
`define CCF_LPF_SH         6

// swap persistence time
`define CCF_CLK_KHZ        40000
`define CCF_SWAP_MS        3000
`define CCF_SWAP_CYC       (`CCF_SWAP_MS * `CCF_CLK_KHZ)

`endif

// ### hw/ccf_pkg.sv
// types shared by the current channel fault select block
// assumes ccf_regs.svh is included by the users of the constants
package ccf_pkg;

  // automatic channel selector, one-hot
  typedef enum logic [1:0] {
    CCF_ON_A = 2'b01,
    CCF_ON_B = 2'b10
  } ccf_sel_e;

  typedef logic signed [24:0] ccf_samp_t;

endpackage

// ### tb/ccf_adc_model.sv
// adc sample stream model: one strobe every GAP clocks while run is high
// assumes the bench sets sample values; unqualified lines toggle each cycle
`timescale 1ns/1ps
`default_nettype none

module ccf_adc_model #(
  parameter int unsigned GAP = 4
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // control from the bench
  input  wire logic               run,
  input  wire logic signed [23:0] ia_set,
  input  wire logic signed [23:0] ib_set,
  input  wire logic signed [23:0] v_set,
  // sample streams
  output logic                    samp_valid,
  output logic signed [23:0]      ia,
  output logic signed [23:0]      ib,
  output logic signed [23:0]      v
);
  logic [7:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q      <= 8'h00;
      samp_valid <= 1'b0;
      ia         <= 24'h000000;
      ib         <= 24'h000000;
      v          <= 24'h000000;
    end else if (run && cnt_q == 8'h00) begin
      cnt_q      <= 8'(GAP - 1);
      samp_valid <= 1'b1;
      ia         <= ia_set;
      ib         <= ib_set;
      v          <= v_set;
    end else begin
      // unqualified lines toggle, so they match the last sample only every other cycle
      if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      samp_valid <= 1'b0;
      ia         <= ~ia;
      ib         <= ~ib;
      v          <= ~v;
    end
  end
endmodule // ccf_adc_model

`default_nettype wire

// ### tb/current_channel_fault_select_tb_top.sv
// self-checking bench for ccf_top: ahb-lite master, adc model, random trims
// assumes ccf_regs.svh on the include path and a short swap persistence
`timescale 1ns/1ps
`default_nettype none
`include "ccf_regs.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end

module current_channel_fault_select_tb_top import ccf_pkg::*;;
  localparam logic [7:0] IDX [6] = '{`CCF_IDX_MODE_ONE_CONTROL, `CCF_IDX_ACCUMULATION_MODE_CONTROL, `CCF_IDX_GAIN,
                                     `CCF_IDX_CALIBRATION_MODE_CONTROL, `CCF_IDX_STATUS, 8'h22};
  logic               hclk    = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel    = 1'b0;
  logic [31:0]        haddr   = 32'h0;
  logic [1:0]         htrans  = 2'b00;
  logic               hwrite  = 1'b0;
  logic [31:0]        hwdata  = 32'h0;
  logic               run     = 1'b0;
  logic signed [23:0] ia_set  = 24'sh0;
  logic signed [23:0] ib_set  = 24'sh0;
  logic signed [23:0] v_set   = 24'sh0;
  logic [31:0]        rd;
  wire logic          hreadyout, hresp, samp_valid, i_meas_valid, zx, p05, p12, irq;
  wire logic [31:0]   hrdata;
  wire logic signed [23:0] fa, fb, vs;
  wire logic signed [24:0] i_meas;
  int                 seed = 93089;
  int                 miscompares = 0;
  int                 n_compared = 0;

  always #12.5 hclk = ~hclk;

  ccf_adc_model #(.GAP(4)) u_ccf_adc_model (.hclk(hclk), .hresetn(hresetn), .run(run),
    .ia_set(ia_set), .ib_set(ib_set), .v_set(v_set), .samp_valid(samp_valid),
    .ia(fa), .ib(fb), .v(vs));

  ccf_top #(.SWAP_CYCLES(16)) u_ccf_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .samp_valid(samp_valid), .first_current_input(fa), .second_current_input(fb),
    .voltage_sample(vs), .i_meas(i_meas), .i_meas_valid(i_meas_valid),
    .zero_cross_signal(zx), .p0_5_zx(p05), .p1_2_zx(p12), .irq(irq));

  function automatic ccf_samp_t exp_trim(input logic signed [23:0] b,
                                         input logic signed [11:0] g);
    logic signed [36:0] p;
    p = b * g;
    return ccf_samp_t'(b) + ccf_samp_t'(p >>> 12);
  endfunction

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    `CHK({hresp, rd & m}, {1'b0, e})
  endtask

  task automatic samples(input int n);
    repeat (n) do @(posedge hclk); while (i_meas_valid !== 1'b1);
  endtask

  task automatic wait_irq(input logic lvl);
    int k;
    k = 0;
    while (irq !== lvl && k < 30000) begin
      @(posedge hclk);
      k++;
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    final_report();
  end

  initial begin
    logic signed [11:0] g;
    logic signed [23:0] a;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(IDX[i], 32'hFFFF_FFFF, 32'h0);
    `CHK(irq, 1'b0)
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      // strobes paused while gain and samples change together
      run <= 1'b0;
      g = (k == 0) ? 12'sh7FF : (k == 1) ? 12'sh800 : 12'($random(seed));
      a = 24'($random(seed)) >>> 1;
      ia_set <= a;
      // second input scaled so the trimmed value matches the first: no auto swap
      ib_set <= 24'((48'(a) * 48'sh1000) / (48'sh1000 + 48'(g)));
      bus(1'b1, `CCF_IDX_GAIN, {20'h0, g});
      run <= 1'b1;
      rchk(`CCF_IDX_GAIN, 32'hFFFF_FFFF, {20'h0, g});
      bus(1'b1, `CCF_IDX_CALIBRATION_MODE_CONTROL, 32'h20);
      samples(2);
      `CHK(i_meas, exp_trim(ib_set, g))
      bus(1'b1, `CCF_IDX_CALIBRATION_MODE_CONTROL, 32'h10);
      samples(2);
      `CHK(i_meas, 25'(ia_set))
      bus(1'b1, `CCF_IDX_CALIBRATION_MODE_CONTROL, k[0] ? 32'h30 : 32'h00);
      samples(2);
      `CHK(i_meas, 25'(ia_set))
    end
    $display("test trim and forced select done");
    bus(1'b1, `CCF_IDX_GAIN, 32'h0);
    bus(1'b1, `CCF_IDX_STATUS, 32'h30);
    bus(1'b1, `CCF_IDX_IRQEN, 32'h20);
    ia_set <= 24'sd400000;
    ib_set <= 24'sd800000;
    wait_irq(1'b1);
    `CHK(irq, 1'b1)
    rchk(`CCF_IDX_STATUS, 32'h20, 32'h20);
    rchk(`CCF_IDX_ACCUMULATION_MODE_CONTROL, 32'h80, 32'h80);
    samples(2);
    `CHK(i_meas, 25'(ib_set))
    bus(1'b1, `CCF_IDX_STATUS, 32'h20);
    rchk(`CCF_IDX_STATUS, 32'h20, 32'h0);
    `CHK(irq, 1'b0)
    ia_set <= 24'sd800000;
    ib_set <= 24'sd400000;
    wait_irq(1'b1);
    rchk(`CCF_IDX_ACCUMULATION_MODE_CONTROL, 32'h80, 32'h00);
    bus(1'b1, `CCF_IDX_STATUS, 32'h20);
    $display("test swap and return done");
    bus(1'b1, `CCF_IDX_IRQEN, 32'h00);
    bus(1'b1, `CCF_IDX_ACCUMULATION_MODE_CONTROL, 32'h40);
    ib_set <= 24'sd800000;
    samples(1000);
    rchk(`CCF_IDX_STATUS, 32'h20, 32'h20);
    `CHK(irq, 1'b0)
    bus(1'b1, `CCF_IDX_IRQEN, 32'h20);
    wait_irq(1'b1);
    `CHK(irq, 1'b1)
    bus(1'b1, `CCF_IDX_ACCUMULATION_MODE_CONTROL, 32'h00);
    bus(1'b1, `CCF_IDX_IRQEN, 32'h00);
    $display("test indication mode done");
    bus(1'b1, `CCF_IDX_MODE_ONE_CONTROL, 32'h20);
    rchk(`CCF_IDX_MODE_ONE_CONTROL, 32'hFF, 32'h20);
    samples(50);
    `CHK(i_meas !== 25'(ia_set), 1'b1)
    bus(1'b1, `CCF_IDX_MODE_ONE_CONTROL, 32'h00);
    samples(2);
    `CHK(i_meas, 25'(ia_set))
    $display("test integrator done");
    bus(1'b1, `CCF_IDX_ZXROUTE, 32'h3);
    v_set <= -24'sd1000000;
    samples(300);
    `CHK({zx, p05, p12}, 3'b000)
    v_set <= 24'sd1000000;
    samples(2);
    `CHK(zx, 1'b0)
    samples(300);
    `CHK({zx, p05, p12}, 3'b111)
    bus(1'b1, `CCF_IDX_MODE_ONE_CONTROL, 32'h40);
    v_set <= -24'sd1000000;
    samples(2);
    `CHK(zx, 1'b0)
    $display("test zero cross done");
    final_report();
  end
endmodule // current_channel_fault_select_tb_top

`default_nettype wire
